// file: hw/tiu_pkg.sv
// ============================================================
// Shared constants and types for the timer, I/O and unpack unit
// ============================================================
// Assumes one clock domain; pins are synchronised inside the top module.
package tiu_pkg;
   localparam int ACC_W = 10;
   localparam int BYTE_W = 8;
   localparam int PTR_W_DEF = 14;
   localparam int TICK_DIV = 48;
   localparam int FIFO_DEPTH_DEF = 32;
   localparam int CNT_W = 4;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_FULL = 8'hff;
   // Frame timer value that speech software must load
   localparam logic [7:0] TIMER_SYNTH = 8'h1f;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Slave-mode control pin positions on port C
   localparam int PC_RW = 3;
   localparam int PC_UPPER = 2;
   localparam int PC_LOWER = 1;
   localparam int PC_RDY = 0;
   localparam int NIB_W = 4;

   typedef enum logic [4:0] {
      op_none, timer_load_op, timer_read_op, internal_tick_select_op, preset_load_op,
      index_load_op, index_swap_op, irq_return_op, jump_if_flag, short_jump_if_flag,
      call_if_flag, synth_start_op, pitch_ram_load_op, rom_ptr_high_load_op,
      rom_ptr_low_load_op, unpack_init_op, bit_fetch_op, internal_rom_select_op,
      external_rom_select_op, port_a_write_op, port_a_read_op, port_a_to_ram_op,
      ready_clear_op, port_c_read_op, port_b_write_op, port_d_write_op
   } tiu_op_t;

   typedef struct packed {
      logic valid;
      tiu_op_t op;
      logic [ACC_W-1:0] acc;
      logic [2:0] bits_m1;
      logic [BYTE_W-1:0] ram_data;
   } tiu_req_t;

   typedef struct packed {
      logic valid;
      logic to_ram;
      logic [ACC_W-1:0] data;
   } tiu_res_t;
endpackage

// file: hw/tiu_top.sv
// ============================================================
// Timer, I/O port and speech unpack unit with host FIFO
// ============================================================
// Contract
// - Timer steps on each prescaler wrap
// - Timer wrap raises pending interrupt request
// - Timer halts after wrap until reloaded
// - Timer loaded from index, read to accumulator
// - Prescaler reloads preset latch on wrap
// - Prescaler clock: internal 1/48 or event pin
// - Timer read selects event pin; tick op internal
// - Index register addresses RAM, saved on interrupt
// - Scratch swaps with index, never saved
// - Jumps and calls act only when flag set
// - Start loads pitch from accumulator, later RAM
// - Pointer loads high/low; byte load increments it
// - Init clears bit counter; fetch 1-8 bits
// - Select internal or external byte source
// - Port B is ROM port in external mode
// - Ports B and D low at power-up
// - Master port A write drives, read captures
// - Port C 3..0 carry host handshake in slave
// - Low nibble write sets busy until clear op
// - Master port C read copies pins
// - Upper strobe bits 7..4, lower bits 3..0
// Assumes requests come from the processor on mclk; pins are asynchronous.
`timescale 1ns/1ps

// ============================================================
// Host-write FIFO
// ============================================================
module tiu_fifo
   import tiu_pkg::*;
#(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH_DEF
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_chk
      $error("tiu_fifo depth must be a power of two of at least 2");
   end

   // Honest flags straight from the occupancy count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage written by index; no reset needed on data
   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and occupancy
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

// ============================================================
// Top module
// ============================================================
module tiu_top
   import tiu_pkg::*;
#(
   parameter int PTR_W = PTR_W_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic master_pin,
   input wire tiu_req_t req,
   input wire logic status_flag,
   input wire logic irq_enable,
   input wire logic [BYTE_W-1:0] rom_data,
   input wire logic event_irq_pin,
   input wire logic [BYTE_W-1:0] pa_in,
   output logic [BYTE_W-1:0] pa_out,
   output logic pa_oe_n,
   input wire logic [BYTE_W-1:0] pb_in,
   output logic [BYTE_W-1:0] pb_out,
   output logic pb_oe_n,
   input wire logic [BYTE_W-1:0] pc_in,
   output logic pc_rdy_out,
   output logic pc_rdy_oe_n,
   output logic [BYTE_W-1:0] pd_out,
   output tiu_res_t res,
   output logic jump_taken,
   output logic irq_take,
   output logic [BYTE_W-1:0] ram_index_reg,
   output logic [BYTE_W-1:0] pitch_period_reg,
   output logic [PTR_W-1:0] rom_pointer,
   output logic [BYTE_W-1:0] frame_timer
);
   localparam int SYN_W = 3 * BYTE_W + 2;
   localparam int TDIV_W = $clog2(TICK_DIV);

   if (PTR_W < 13 || PTR_W > 14)
   begin : g_chk
      $error("tiu_top pointer width must be 13 or 14");
   end

   logic [SYN_W-1:0] sync1, sync2;
   logic master, ev_q, ev_prev, upper_prev, lower_prev;
   logic [BYTE_W-1:0] pa_s, pb_s, pc_s;
   logic [TDIV_W-1:0] tick_cnt;
   logic int_tick, ext_sel, tick, presc_wrap, timer_running, irq_pend;
   logic [BYTE_W-1:0] timer_prescaler, preset_latch, scratch_reg, index_save;
   logic [BYTE_W-1:0] unpack_shift_reg, src_byte, host_hi;
   logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
   logic [2*BYTE_W-1:0] window;
   logic [BYTE_W-1:0] fetched;
   logic ext_rom, busy, upper_end, lower_end, host_wr, host_rd;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [BYTE_W-1:0] fifo_out;

   // Two-flop synchronisers on every pin input; only sync2 is read
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Idle-high reset: no false strobe or event edge once pins come through
         sync1 <= '1;
         sync2 <= '1;
      end
      else
      begin
         sync1 <= {master_pin, event_irq_pin, pc_in, pb_in, pa_in};
         sync2 <= sync1;
      end
   end
   assign {master, ev_q, pc_s, pb_s, pa_s} = sync2;

   // Previous levels for edge detection of event pin and strobes
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ev_prev <= 1'b1;
         upper_prev <= 1'b1;
         lower_prev <= 1'b1;
      end
      else
      begin
         ev_prev <= ev_q;
         upper_prev <= pc_s[PC_UPPER];
         lower_prev <= pc_s[PC_LOWER];
      end
   end

   // Strobes are active low; data is taken at the rising (trailing) edge
   assign upper_end = !master && pc_s[PC_UPPER] && !upper_prev;
   assign lower_end = !master && pc_s[PC_LOWER] && !lower_prev;
   assign host_wr = !pc_s[PC_RW];
   assign host_rd = !master && pc_s[PC_RW] && !(pc_s[PC_UPPER] && pc_s[PC_LOWER]);

   // Internal tick every 48 clocks
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         tick_cnt <= '0;
      else if (tick_cnt == TDIV_W'(TICK_DIV - 1))
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 1'b1;
   end
   assign int_tick = (tick_cnt == TDIV_W'(TICK_DIV - 1));
   // Event pin counts on its falling edge
   assign tick = ext_sel ? (ev_prev && !ev_q) : int_tick;
   assign presc_wrap = tick && (timer_prescaler == BYTE_ZERO);

   // Clock source select
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         ext_sel <= 1'b0;
      else if (req.valid && req.op == timer_read_op)
         ext_sel <= 1'b1;
      else if (req.valid && req.op == internal_tick_select_op)
         ext_sel <= 1'b0;
   end

   // Prescaler counts down, reloads from preset latch on wrap
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timer_prescaler <= BYTE_FULL;
         preset_latch <= BYTE_FULL;
      end
      else
      begin
         if (req.valid && req.op == preset_load_op)
            preset_latch <= req.acc[BYTE_W-1:0];
         if (presc_wrap)
            timer_prescaler <= preset_latch;
         else if (tick)
            timer_prescaler <= timer_prescaler - 1'b1;
      end
   end

   // Frame timer: load wins over count; halts after wrap
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         frame_timer <= BYTE_ZERO;
         timer_running <= 1'b0;
      end
      else if (req.valid && req.op == timer_load_op)
      begin
         frame_timer <= ram_index_reg;
         timer_running <= 1'b1;
      end
      else if (presc_wrap && timer_running)
      begin
         frame_timer <= frame_timer - 1'b1;
         if (frame_timer == BYTE_ZERO)
            timer_running <= 1'b0;
      end
   end

   // Pending request; a new wrap wins over the take
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_pend <= 1'b0;
         irq_take <= 1'b0;
      end
      else
      begin
         irq_take <= irq_pend && irq_enable && !irq_take;
         if (presc_wrap && timer_running && frame_timer == BYTE_ZERO)
            irq_pend <= 1'b1;
         else if (irq_take)
            irq_pend <= 1'b0;
      end
   end

   // Index and scratch; index saved on take, restored on return
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ram_index_reg <= BYTE_ZERO;
         scratch_reg <= BYTE_ZERO;
         index_save <= BYTE_ZERO;
      end
      else
      begin
         if (irq_take)
            index_save <= ram_index_reg;
         if (req.valid && req.op == index_load_op)
            ram_index_reg <= req.acc[BYTE_W-1:0];
         else if (req.valid && req.op == index_swap_op)
         begin
            ram_index_reg <= scratch_reg;
            scratch_reg <= ram_index_reg;
         end
         else if (req.valid && req.op == irq_return_op)
            ram_index_reg <= index_save;
      end
   end

   // Conditional transfers follow the status flag
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         jump_taken <= 1'b0;
      else
         jump_taken <= req.valid && status_flag && (req.op == jump_if_flag
            || req.op == short_jump_if_flag || req.op == call_if_flag);
   end

   // Pitch from accumulator on start, from RAM afterwards
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         pitch_period_reg <= BYTE_ZERO;
      else if (req.valid && req.op == synth_start_op)
         pitch_period_reg <= req.acc[BYTE_W-1:0];
      else if (req.valid && req.op == pitch_ram_load_op)
         pitch_period_reg <= req.ram_data;
   end

   // Byte source: internal ROM or port B pins
   assign src_byte = ext_rom ? pb_s : rom_data;
   assign window = {unpack_shift_reg, src_byte} << bit_cnt;
   assign fetched = window[2*BYTE_W-1:BYTE_W] >> (3'd7 - req.bits_m1);
   assign next_bit_cnt = bit_cnt + CNT_W'(req.bits_m1) + 1'b1;

   // Pointer, shift register and bit counter
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rom_pointer <= '0;
         unpack_shift_reg <= BYTE_ZERO;
         bit_cnt <= '0;
      end
      else if (req.valid)
      begin
         case (req.op)
            rom_ptr_high_load_op:
               rom_pointer[PTR_W-1:BYTE_W] <= req.acc[PTR_W-BYTE_W-1:0];
            rom_ptr_low_load_op:
               rom_pointer[BYTE_W-1:0] <= req.acc[BYTE_W-1:0];
            unpack_init_op:
            begin
               unpack_shift_reg <= src_byte;
               bit_cnt <= '0;
               rom_pointer <= rom_pointer + 1'b1;
            end
            bit_fetch_op:
               if (next_bit_cnt >= BITS_PER_BYTE)
               begin
                  unpack_shift_reg <= src_byte; // Refill when emptied
                  bit_cnt <= next_bit_cnt - BITS_PER_BYTE;
                  rom_pointer <= rom_pointer + 1'b1;
               end
               else
                  bit_cnt <= next_bit_cnt;
            default:
               bit_cnt <= bit_cnt;
         endcase
      end
   end

   // Source mode and port B; external mode releases the pins
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ext_rom <= 1'b0;
         pb_out <= BYTE_ZERO;
         pb_oe_n <= 1'b0;
         pd_out <= BYTE_ZERO;
      end
      else if (req.valid)
      begin
         if (req.op == external_rom_select_op)
         begin
            ext_rom <= 1'b1;
            pb_oe_n <= 1'b1;
         end
         else if (req.op == internal_rom_select_op)
         begin
            ext_rom <= 1'b0; // Caller must have released the external ROM
            pb_oe_n <= 1'b0;
         end
         if (req.op == port_b_write_op)
            pb_out <= req.acc[BYTE_W-1:0];
         if (req.op == port_d_write_op)
            pd_out <= req.acc[BYTE_W-1:0];
      end
   end

   // Host writes assemble a byte; low nibble completes it
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         host_hi <= BYTE_ZERO;
      else if (upper_end && host_wr)
         host_hi <= pa_s;
   end

   // Full FIFO stalls the host through the ready pin
   tiu_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .arst_n(arst_n),
      .in_valid(lower_end && host_wr),
      .in_ready(fifo_in_ready),
      .in_data({host_hi[BYTE_W-1:NIB_W], pa_s[NIB_W-1:0]}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );
   assign fifo_pop = !master && req.valid
      && (req.op == port_a_read_op || req.op == port_a_to_ram_op);

   // Busy set by low nibble write, cleared by clear op; set wins
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         busy <= 1'b0;
      else if (lower_end && host_wr)
         busy <= 1'b1;
      else if (req.valid && req.op == ready_clear_op)
         busy <= 1'b0;
   end

   // Ready pin: high means not ready; driven only in slave mode
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pc_rdy_out <= 1'b0;
         pc_rdy_oe_n <= 1'b1;
      end
      else
      begin
         pc_rdy_out <= busy || !fifo_in_ready;
         pc_rdy_oe_n <= master;
      end
   end

   // Port A direction: master by ops, slave by host read strobes
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pa_out <= BYTE_ZERO;
         pa_oe_n <= 1'b1;
      end
      else
      begin
         if (req.valid && req.op == port_a_write_op)
            pa_out <= req.acc[BYTE_W-1:0];
         if (!master)
            pa_oe_n <= !host_rd;
         else if (req.valid && req.op == port_a_write_op)
            pa_oe_n <= 1'b0;
         else if (req.valid && (req.op == port_a_read_op || req.op == port_a_to_ram_op))
            pa_oe_n <= 1'b1;
      end
   end

   // Results returned to the processor one cycle after the request
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         res <= '0;
      else
      begin
         res.valid <= req.valid && (req.op == timer_read_op || req.op == bit_fetch_op
            || req.op == port_a_read_op || req.op == port_a_to_ram_op
            || req.op == port_c_read_op);
         res.to_ram <= req.valid && req.op == port_a_to_ram_op;
         case (req.op)
            timer_read_op: res.data <= ACC_W'(frame_timer);
            bit_fetch_op: res.data <= ACC_W'(fetched);
            port_a_read_op, port_a_to_ram_op:
               res.data <= ACC_W'(master ? pa_s : fifo_out);
            port_c_read_op:
               res.data <= master ? ACC_W'(pc_s)
                  : ACC_W'(pc_s[BYTE_W-1:NIB_W]);
            default: res.data <= '0;
         endcase
      end
   end

   // ============================================================
   // Assertions
   // ============================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   timer_step_a: assert property (presc_wrap && timer_running
      && !(req.valid && req.op == timer_load_op)
      |=> frame_timer == $past(frame_timer) - 8'h01)
      else $error("frame timer did not step on prescaler wrap");
   timer_irq_a: assert property (presc_wrap && timer_running && frame_timer == BYTE_ZERO
      |=> irq_pend ##1 (irq_pend || irq_take))
      else $error("timer wrap did not raise a request");
   timer_halt_a: assert property (!timer_running
      && !(req.valid && req.op == timer_load_op) |=> $stable(frame_timer))
      else $error("halted timer changed");
   timer_read_a: assert property (req.valid && req.op == timer_read_op
      |=> res.valid && res.data == ACC_W'($past(frame_timer)) && ext_sel)
      else $error("timer read wrong");
   presc_reload_a: assert property (presc_wrap
      |=> timer_prescaler == $past(preset_latch))
      else $error("prescaler did not reload");
   tick_period_a: assert property (int_tick |=> !int_tick ##47 int_tick)
      else $error("internal tick period wrong");
   index_swap_a: assert property (req.valid && req.op == index_swap_op
      |=> ram_index_reg == $past(scratch_reg) && scratch_reg == $past(ram_index_reg))
      else $error("index swap wrong");
   jump_flag_a: assert property (req.valid && req.op == jump_if_flag
      |=> jump_taken == $past(status_flag))
      else $error("jump ignored status flag");
   unpack_ptr_a: assert property (req.valid && req.op == unpack_init_op
      |=> rom_pointer == $past(rom_pointer) + 1'b1 && bit_cnt == '0)
      else $error("unpack init wrong");
   busy_set_a: assert property (lower_end && host_wr |=> busy ##1 pc_rdy_out)
      else $error("low nibble write did not set busy");

   wrap_c: cover property (presc_wrap && timer_running && frame_timer == BYTE_ZERO);
   refill_c: cover property (req.valid && req.op == bit_fetch_op
      && next_bit_cnt >= BITS_PER_BYTE);
   host_write_c: cover property (lower_end && host_wr ##[1:40] fifo_pop);
endmodule

// file: testbench/timer_io_unpack_unit_bench.sv
// ============================================================
// Self-checking bench for the timer, I/O and unpack unit
// ============================================================
// Assumes tiu_top defaults; inputs change on the falling edge.
`timescale 1ns/1ps
module timer_io_unpack_unit_bench;
   import tiu_pkg::*;
   typedef struct {tiu_op_t op; logic [9:0] acc; logic [2:0] bm; logic flag; int sel;
      logic [15:0] exp;} tiu_row_t;
   logic mclk, arst_n, master_pin, status_flag, irq_enable, event_irq_pin, pa_oe_n, pb_oe_n;
   logic pc_rdy_out, pc_rdy_oe_n, jump_taken, irq_take, hit;
   logic [7:0] rom_data, pa_out, pb_out, pd_out, ram_index_reg, pitch_period_reg;
   logic [7:0] frame_timer, host_pa;
   logic [3:1] host_pc;
   logic [13:0] rom_pointer;
   tiu_req_t req;
   tiu_res_t res;
   int n_fail, checked, i, k;
   tiu_row_t rows[] = '{
      '{index_load_op, 10'h05a, 0, 0, 1, 16'h005a},
      '{index_swap_op, 0, 0, 0, 0, 0},
      '{index_load_op, 10'h033, 0, 0, 1, 16'h0033},
      '{index_swap_op, 0, 0, 0, 1, 16'h005a},
      '{jump_if_flag, 0, 0, 0, 2, 0}, '{jump_if_flag, 0, 0, 1, 2, 1},
      '{short_jump_if_flag, 0, 0, 1, 2, 1}, '{call_if_flag, 0, 0, 0, 2, 0},
      '{synth_start_op, 10'h2c7, 0, 0, 3, 16'h00c7},
      '{pitch_ram_load_op, 0, 0, 0, 3, 0},
      '{port_d_write_op, 10'h3a5, 0, 0, 4, 16'h00a5},
      '{port_a_write_op, 10'h1e4, 0, 0, 5, 16'h00e4},
      '{port_a_read_op, 0, 0, 0, 0, 0}, '{port_a_read_op, 0, 0, 0, 0, 0},
      '{port_a_to_ram_op, 0, 0, 0, 7, 16'h0cc3},
      '{port_c_read_op, 0, 0, 0, 7, 16'h0897},
      '{rom_ptr_high_load_op, 10'h015, 0, 0, 6, 16'h1500},
      '{rom_ptr_low_load_op, 10'h0fe, 0, 0, 6, 16'h15fe},
      '{unpack_init_op, 0, 0, 0, 6, 16'h15ff},
      '{bit_fetch_op, 0, 3, 0, 7, 16'h080c}, '{bit_fetch_op, 0, 7, 0, 7, 16'h085c},
      '{external_rom_select_op, 0, 0, 0, 8, 1}, '{external_rom_select_op, 0, 0, 0, 8, 1},
      '{unpack_init_op, 0, 0, 0, 0, 0}, // Port B pins pass two sync flops first
      '{bit_fetch_op, 0, 7, 0, 7, 16'h0869},
      '{internal_rom_select_op, 0, 0, 0, 8, 0},
      '{port_b_write_op, 10'h15a, 0, 0, 9, 16'h005a}};

   // Port B far side: the ROM model lets go whenever the port drives
   tiu_top i_dut (.mclk(mclk), .arst_n(arst_n), .master_pin(master_pin), .req(req),
      .status_flag(status_flag), .irq_enable(irq_enable), .rom_data(rom_data),
      .event_irq_pin(event_irq_pin), .pa_in(pa_oe_n ? host_pa : pa_out), .pa_out(pa_out),
      .pa_oe_n(pa_oe_n), .pb_in(pb_oe_n ? 8'h69 : pb_out), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
      .pc_in({4'h9, host_pc, pc_rdy_oe_n ? 1'b1 : pc_rdy_out}), .pc_rdy_out(pc_rdy_out),
      .pc_rdy_oe_n(pc_rdy_oe_n), .pd_out(pd_out), .res(res), .jump_taken(jump_taken),
      .irq_take(irq_take), .ram_index_reg(ram_index_reg), .pitch_period_reg(pitch_period_reg),
      .rom_pointer(rom_pointer), .frame_timer(frame_timer));
   tiu_host_model i_host (.mclk(mclk), .pa_drv(host_pa), .pc_ctl(host_pc));

   // Free-running 125 MHz clock
   initial
   begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic wrap_up;
      if (n_fail == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // A bound that ran out ends the run as a failure
   task automatic bounded(input int used, input int lim);
      if (used >= lim)
      begin
         n_fail++;
         wrap_up();
      end
   endtask

   // One-cycle request; its answer is sampled at the next falling edge
   task automatic do_op(input tiu_op_t op, input logic [9:0] acc, input logic [2:0] bm,
      input logic flag);
      @(negedge mclk);
      req.valid = 1;
      req.op = op;
      req.acc = acc;
      req.bits_m1 = bm;
      status_flag = flag;
      @(negedge mclk);
      req.valid = 0;
   endtask

   function automatic logic [15:0] seen(input int sel);
      case (sel)
         1: return {8'h00, ram_index_reg};
         2: return {15'h0000, jump_taken};
         3: return {8'h00, pitch_period_reg};
         4: return {8'h00, pd_out};
         5: return {7'h00, pa_oe_n, pa_out};
         6: return {2'h0, rom_pointer};
         7: return {4'h0, res.valid, res.to_ram, res.data};
         9: return {8'h00, pb_out};
         default: return {15'h0000, pb_oe_n};
      endcase
   endfunction

   // Main sequence: table, then timer, event pin and host link
   initial
   begin
      n_fail = 0;
      checked = 0;
      req = '0;
      {arst_n, status_flag, irq_enable} = 3'b000;
      {master_pin, event_irq_pin} = 2'b11;
      rom_data = 8'hc5;
      repeat (12) @(negedge mclk);
      arst_n = 1;
      repeat (4) @(negedge mclk);
      foreach (rows[r])
      begin
         do_op(rows[r].op, rows[r].acc, rows[r].bm, rows[r].flag);
         if (rows[r].sel != 0)
            check(seen(rows[r].sel), rows[r].exp);
      end
      do_op(preset_load_op, 10'h000, 0, 0);
      do_op(index_load_op, 10'h01f, 0, 0);
      do_op(timer_load_op, 0, 0, 0);
      check(frame_timer, 16'h001f);
      for (i = 0; i < 20000 && frame_timer !== 8'hff; i++) @(negedge mclk);
      bounded(i, 20000);
      hit = 0;
      repeat (20) @(negedge mclk) hit |= irq_take;
      check(hit, 0);
      irq_enable = 1;
      for (i = 0; i < 6 && irq_take !== 1'b1; i++) @(negedge mclk);
      check(i < 6, 1);
      do_op(index_load_op, 10'h0aa, 0, 0);
      do_op(irq_return_op, 0, 0, 0);
      check(ram_index_reg, 16'h001f);
      repeat (200) @(negedge mclk);
      check(frame_timer, 16'h00ff);
      do_op(timer_read_op, 0, 0, 0);
      check(res.data, 16'h00ff);
      do_op(index_load_op, 10'h001, 0, 0);
      do_op(timer_load_op, 0, 0, 0);
      // Each falling event is one prescaler wrap since the preset is zero
      for (k = 0; k < 2; k++)
      begin
         repeat (10) @(negedge mclk) event_irq_pin = 0;
         repeat (10) @(negedge mclk) event_irq_pin = 1;
         check(frame_timer, k ? 16'h00ff : 16'h0000);
      end
      do_op(internal_tick_select_op, 0, 0, 0);
      // Preset zero: the one internal tick in 48 clocks steps the timer once
      do_op(timer_load_op, 0, 0, 0);
      repeat (48) @(negedge mclk);
      check(frame_timer, 16'h0000);
      master_pin = 0;
      arst_n = 0;
      repeat (12) @(negedge mclk);
      check({pb_out, pd_out}, 16'h0000);
      arst_n = 1;
      repeat (5) @(negedge mclk);
      check(pc_rdy_oe_n, 0);
      i_host.write_byte(8'ha7);
      check(pc_rdy_out, 1);
      do_op(port_a_read_op, 0, 0, 0);
      check(res.data, 16'h00a7);
      check(pc_rdy_out, 1);
      do_op(ready_clear_op, 0, 0, 0);
      repeat (3) @(negedge mclk);
      check(pc_rdy_out, 0);
      // The 33rd byte meets a full buffer and is dropped
      for (k = 0; k < 33; k++) i_host.write_byte(k[7:0]);
      do_op(ready_clear_op, 0, 0, 0);
      repeat (3) @(negedge mclk);
      check(pc_rdy_out, 1);
      for (k = 0; k < 32; k++)
      begin
         do_op(port_a_read_op, 0, 0, 0);
         check(res.data, k[15:0]);
      end
      do_op(ready_clear_op, 0, 0, 0);
      repeat (3) @(negedge mclk);
      check(pc_rdy_out, 0);
      wrap_up();
   end
endmodule

// file: testbench/tiu_host_model.sv
// ============================================================
// External host model: writes port A bytes as two nibbles
// ============================================================
// Assumes the bench resolves port A pins and calls write_byte.
`timescale 1ns/1ps
module tiu_host_model
(
   input wire logic mclk,
   output logic [7:0] pa_drv,
   output logic [3:1] pc_ctl
);
   logic [7:0] last_pa = 8'h3c;
   // A released port shows the inverse of the last byte, never a kind copy
   initial
   begin
      pa_drv = ~last_pa;
      pc_ctl = 3'b011;
   end
   // Upper nibble strobe, then lower; rw low for a write
   task automatic write_byte(input logic [7:0] b);
      @(negedge mclk);
      pa_drv = b;
      @(negedge mclk);
      pc_ctl = 3'b001;
      repeat (5) @(negedge mclk);
      pc_ctl = 3'b011;
      repeat (5) @(negedge mclk);
      pc_ctl = 3'b010;
      repeat (5) @(negedge mclk);
      pc_ctl = 3'b011;
      repeat (5) @(negedge mclk);
      last_pa = b;
      pa_drv = ~b;
   endtask
endmodule
